// >>> design/modbus_ascii_mode_control.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_ascii_mode_control
    import modbus_mode_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         rxdPin,
    output logic              txdPin,
    output logic              txdEnable,
    input  wire link_cfg_type storedCfg,
    input  wire logic         softRestart,
    input  wire logic         asciiSave,
    output link_cfg_type      activeCfg,
    output logic              forcedAscii,
    output logic              nvmWrite,
    output link_cfg_type      nvmData
);

    ctl_state_type state_q;
    ctl_state_type state_d;

    logic         rxMeta_q;
    logic         rxSync_q;
    logic         booting_q;
    logic [1:0]   bootCnt_q;
    logic         forced_q;
    link_cfg_type active_q;
    link_cfg_type pending_q;
    link_cfg_type pendingNext;
    link_cfg_type bootCfg;
    logic         strapForced;

    logic [15:0]  group_q;
    logic [15:0]  item_q;
    logic [31:0]  value_q;
    logic         nvmWrite_q;
    link_cfg_type nvmData_q;

    logic [2:0]   baudSel;
    logic [15:0]  bitCycles;
    logic [15:0]  tickCnt_q;
    logic         bitTick;

    logic         rxValid;
    logic [7:0]   rxData;
    logic         rxBad;
    logic [7:0]   rxBuf [0:FRAME_MAX-1];
    logic [4:0]   rxCount_q;
    logic         frameBad_q;
    logic [5:0]   gap_q;
    logic         rxRoom;
    logic         clearing;
    logic         frameEnd;
    logic [15:0]  crcRx;
    logic [15:0]  crcTx;

    logic [7:0]   fc;
    logic [15:0]  regIdx;
    logic [15:0]  qty;
    logic         accept;
    logic         isRead;
    logic         isOne;
    logic         isMany;
    logic         known;
    logic         qtyOk;
    logic         wide;
    logic         lenOk;
    logic         respond;
    logic         idxGroup;
    logic         idxItem;
    logic         idxValue;
    logic         idxSave;
    logic         readMapped;
    logic         writeMapped;
    logic         valueOk;
    logic [7:0]   excCode;
    logic [31:0]  wrVal;
    logic [31:0]  readVal;
    logic         doWrite;
    logic         applyWrite;
    logic         saveHit;
    logic [NUM_RATES-1:0] rateHit;
    logic [2:0]   rateCode;

    logic [6:0][7:0] resp;
    logic [2:0]   respLen;
    logic [6:0][7:0] txData_q;
    logic [2:0]   txLen_q;
    logic [3:0]   txPos_q;
    logic [3:0]   txEnd;
    logic [10:0]  txShift_q;
    logic [3:0]   txBits_q;
    logic         txd_q;
    logic [7:0]   nextByte;
    logic         loadByte;
    logic         txDone;
    logic         txDataByte;

    // Pin is asynchronous; idle level is high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
        end else begin
            rxMeta_q <= rxdPin;
            rxSync_q <= rxMeta_q;
        end
    end

    // Line held at the active (low) level at start-up means forced ASCII
    assign strapForced = !rxSync_q;
    assign bootCfg     = strapForced ? CFG_FORCED : storedCfg;

    // Writes only touch the pending copy; the running mode changes on restart
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            booting_q <= 1'b1;
            bootCnt_q <= BOOT_CYCLES;
            active_q  <= CFG_RESET;
            pending_q <= CFG_RESET;
            forced_q  <= 1'b0;
        end else if (softRestart) begin
            booting_q <= 1'b1;
            bootCnt_q <= BOOT_CYCLES;
        end else if (booting_q) begin
            if (bootCnt_q != 2'h0) begin
                bootCnt_q <= bootCnt_q - 2'h1;
            end else begin
                booting_q <= 1'b0;
                active_q  <= bootCfg;
                pending_q <= bootCfg;
                forced_q  <= strapForced;
            end
        end else if (applyWrite) begin
            pending_q <= pendingNext;
        end
    end

    // Free-running bit tick at the active rate
    assign baudSel   = (active_q.baudCode < 3'(NUM_RATES)) ? active_q.baudCode
                                                           : BAUD_CODE_FORCED;
    assign bitCycles = BIT_CYCLES[baudSel];
    assign bitTick   = (tickCnt_q == 16'h0000);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_q <= 16'h0000;
        end else begin
            tickCnt_q <= bitTick ? bitCycles - 16'h0001 : tickCnt_q - 16'h0001;
        end
    end

    serial_byte_rx u_rx (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .rxLevel   (rxSync_q),
        .bitCycles (bitCycles),
        .byteValid (rxValid),
        .byteData  (rxData),
        .byteBad   (rxBad)
    );

    // Frame ends after a silent gap of about 3.5 characters
    assign rxRoom   = (rxCount_q < 5'(FRAME_MAX));
    assign clearing = (state_q == ST_EXEC) || booting_q;
    assign frameEnd = (state_q == ST_RECV) && (rxCount_q != 5'h00) && (gap_q == GAP_BITS);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxCount_q  <= 5'h00;
            frameBad_q <= 1'b0;
            gap_q      <= 6'h00;
        end else if (clearing) begin
            rxCount_q  <= 5'h00;
            frameBad_q <= 1'b0;
            gap_q      <= 6'h00;
        end else if (rxValid) begin
            rxCount_q  <= rxRoom ? rxCount_q + 5'h01 : rxCount_q;
            frameBad_q <= frameBad_q || rxBad || !rxRoom;
            gap_q      <= 6'h00;
        end else if (bitTick && gap_q != GAP_BITS && rxCount_q != 5'h00) begin
            gap_q <= gap_q + 6'h01;
        end
    end

    // Frame bytes are data, not control; no reset needed
    always_ff @(posedge clk_sys) begin
        if (rxValid && rxRoom) begin
            rxBuf[rxCount_q[3:0]] <= rxData;
        end
    end

    // CRC over the whole frame, its own two bytes included, leaves zero
    modbus_crc16 u_crc_rx (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clear     (clearing),
        .byteValid (rxValid && rxRoom),
        .byteData  (rxData),
        .crc       (crcRx)
    );

    assign fc     = rxBuf[1];
    assign regIdx = {rxBuf[2], rxBuf[3]};
    assign qty    = {rxBuf[4], rxBuf[5]};

    assign accept = !frameBad_q && (crcRx == 16'h0000) && (rxBuf[0] == active_q.nodeAddr)
                    && !active_q.asciiMode;
    assign isRead = (fc == FC_READ_HOLD) || (fc == FC_READ_INPUT);
    assign isOne  = (fc == FC_WRITE_ONE);
    assign isMany = (fc == FC_WRITE_MANY);
    assign known  = isRead || isOne || isMany;
    assign wide   = (qty == 16'h0002);
    assign qtyOk  = (qty == 16'h0001) || wide;
    assign lenOk  = isMany ? (rxCount_q == (wide ? LEN_MANY2 : LEN_MANY1))
                             && (rxBuf[6] == (wide ? BC_TWO : BC_ONE))
                           : (rxCount_q == LEN_SHORT);
    assign respond = accept && (!known || lenOk);

    assign idxGroup    = (regIdx == IDX_GROUP);
    assign idxItem     = (regIdx == IDX_ITEM);
    assign idxValue    = (regIdx == IDX_VALUE);
    assign idxSave     = (regIdx == IDX_SAVE);
    assign readMapped  = idxGroup || idxItem || idxValue;
    assign writeMapped = readMapped || idxSave;

    // Two registers carry a 32-bit value, high word first
    assign wrVal = isOne ? {16'h0000, qty}
                 : wide  ? {rxBuf[7], rxBuf[8], rxBuf[9], rxBuf[10]}
                         : {16'h0000, rxBuf[7], rxBuf[8]};
    assign readVal = idxGroup ? {16'h0000, group_q}
                   : idxItem  ? {16'h0000, item_q} : value_q;

    for (genvar i = 0; i < NUM_RATES; i++) begin : g_rate
        assign rateHit[i] = (wrVal == BAUD_RATE[i]);
    end

    always_comb begin
        rateCode = BAUD_CODE_FORCED;
        for (int k = 0; k < NUM_RATES; k++) begin
            if (rateHit[k]) begin
                rateCode = 3'(k);
            end
        end
    end

    // Only group 0 items steer the link; other items are stored only
    always_comb begin
        pendingNext = pending_q;
        valueOk     = 1'b1;
        if (group_q == GROUP_NET) begin
            if (item_q == ITEM_BAUD) begin
                valueOk              = |rateHit;
                pendingNext.baudCode = rateCode;
            end else if (item_q == ITEM_ADDR) begin
                valueOk              = (wrVal >= ADDR_MIN) && (wrVal <= ADDR_MAX);
                pendingNext.nodeAddr = wrVal[7:0];
            end else if (item_q == ITEM_CHAN) begin
                // 259 also fixes even parity and half duplex (driver enabled only while answering), the only framing here
                valueOk               = (wrVal == CHAN_MODBUS) || (wrVal == CHAN_ASCII);
                pendingNext.asciiMode = (wrVal == CHAN_ASCII);
            end
        end
    end

    always_comb begin
        if (!known) begin
            excCode = EXC_FUNC;
        end else if (!isOne && !qtyOk) begin
            excCode = EXC_VALUE;
        end else if (isRead) begin
            excCode = readMapped ? EXC_NONE : EXC_ADDR;
        end else if (!writeMapped) begin
            excCode = EXC_ADDR;
        end else begin
            excCode = (idxValue && !valueOk) ? EXC_VALUE : EXC_NONE;
        end
    end

    assign doWrite    = (state_q == ST_EXEC) && respond && (excCode == EXC_NONE)
                        && (isOne || isMany);
    assign applyWrite = doWrite && idxValue;
    assign saveHit    = doWrite && idxSave && (wrVal == SAVE_KEY);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            group_q    <= 16'h0000;
            item_q     <= 16'h0000;
            value_q    <= 32'h0000_0000;
            nvmWrite_q <= 1'b0;
            nvmData_q  <= CFG_RESET;
        end else begin
            if (doWrite && idxGroup) begin
                group_q <= wrVal[15:0];
            end
            if (doWrite && idxItem) begin
                item_q <= wrVal[15:0];
            end
            if (applyWrite) begin
                value_q <= wrVal;
            end
            nvmWrite_q <= saveHit || asciiSave;
            if (saveHit || asciiSave) begin
                nvmData_q <= pending_q;
            end
        end
    end

    always_comb begin
        resp    = '0;
        resp[0] = rxBuf[0];
        respLen = LEN_WR;
        if (excCode != EXC_NONE) begin
            resp[1] = fc | FC_EXC_FLAG;
            resp[2] = excCode;
            respLen = LEN_EXC;
        end else if (isRead) begin
            resp[1] = fc;
            resp[2] = wide ? BC_TWO : BC_ONE;
            if (wide) begin
                {resp[3], resp[4], resp[5], resp[6]} = readVal;
                respLen = LEN_RD2;
            end else begin
                {resp[3], resp[4]} = readVal[15:0];
                respLen = LEN_RD1;
            end
        end else begin
            // Both write answers echo index and value or count
            {resp[1], resp[2], resp[3], resp[4], resp[5]} =
                {fc, rxBuf[2], rxBuf[3], rxBuf[4], rxBuf[5]};
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RECV: state_d = frameEnd ? ST_EXEC : ST_RECV;
            ST_EXEC: state_d = respond ? ST_SEND : ST_RECV;
            ST_SEND: state_d = txDone ? ST_RECV : ST_SEND;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RECV;
        end else begin
            state_q <= booting_q ? ST_RECV : state_d;
        end
    end

    // Answer bytes, then CRC low byte, then CRC high byte
    assign txEnd      = {1'b0, txLen_q} + 4'h2;
    assign txDataByte = (txPos_q < {1'b0, txLen_q});
    assign nextByte   = txDataByte ? txData_q[txPos_q[2:0]]
                      : (txPos_q == {1'b0, txLen_q}) ? crcTx[7:0] : crcTx[15:8];
    assign loadByte   = (state_q == ST_SEND) && (txBits_q == 4'h0) && (txPos_q != txEnd);
    // Waiting one more tick keeps the enable up through the last stop bit
    assign txDone     = (txPos_q == txEnd) && (txBits_q == 4'h0) && bitTick;

    modbus_crc16 u_crc_tx (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clear     (state_q == ST_EXEC),
        .byteValid (loadByte && txDataByte),
        .byteData  (nextByte),
        .crc       (crcTx)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txData_q  <= '0;
            txLen_q   <= 3'h0;
            txPos_q   <= 4'h0;
            txShift_q <= 11'h7ff;
            txBits_q  <= 4'h0;
            txd_q     <= 1'b1;
        end else if (clearing) begin
            // A restart mid-answer must not leave bits shifting out later
            txData_q <= resp;
            txLen_q  <= respLen;
            txPos_q  <= 4'h0;
            txBits_q <= 4'h0;
            txd_q    <= 1'b1;
        end else if (loadByte) begin
            txShift_q <= {1'b1, ^nextByte, nextByte, 1'b0};
            txBits_q  <= TX_BITS;
            txPos_q   <= txPos_q + 4'h1;
        end else if (bitTick && txBits_q != 4'h0) begin
            txd_q     <= txShift_q[0];
            txShift_q <= {1'b1, txShift_q[10:1]};
            txBits_q  <= txBits_q - 4'h1;
        end
    end

    assign txdPin      = txd_q;
    assign txdEnable   = (state_q == ST_SEND);
    assign activeCfg   = active_q;
    assign forcedAscii = forced_q;
    assign nvmWrite    = nvmWrite_q;
    assign nvmData     = nvmData_q;

endmodule
`default_nettype wire

// >>> design/modbus_crc16.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_crc16
    import modbus_mode_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    output logic      [15:0] crc
);

    logic [15:0] crc_q;
    logic [15:0] crcStep;

    // Reflected polynomial, one bit per pass
    always_comb begin
        crcStep = crc_q ^ {8'h00, byteData};
        for (int b = 0; b < 8; b++) begin
            crcStep = crcStep[0] ? ((crcStep >> 1) ^ CRC_POLY) : (crcStep >> 1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= CRC_INIT;
        end else if (clear) begin
            crc_q <= CRC_INIT;
        end else if (byteValid) begin
            crc_q <= crcStep;
        end
    end

    assign crc = crc_q;

endmodule
`default_nettype wire

// >>> design/modbus_mode_pkg.sv
package modbus_mode_pkg;

    typedef struct packed {
        logic       asciiMode;
        logic [7:0] nodeAddr;
        logic [2:0] baudCode;
    } link_cfg_type;

    typedef enum logic [2:0] {
        ST_RECV = 3'b001,
        ST_EXEC = 3'b010,
        ST_SEND = 3'b100
    } ctl_state_type;

    localparam int          CLK_HZ    = 32'h0098_9680;
    localparam int          NUM_RATES = 7;
    localparam logic [31:0] BAUD_RATE [0:NUM_RATES-1] = '{
        32'h0000_2580, 32'h0000_4b00, 32'h0000_9600, 32'h0000_e100,
        32'h0001_c200, 32'h0003_8400, 32'h0007_0800
    };
    localparam logic [15:0] BIT_CYCLES [0:NUM_RATES-1] = '{
        16'(CLK_HZ / BAUD_RATE[0]), 16'(CLK_HZ / BAUD_RATE[1]),
        16'(CLK_HZ / BAUD_RATE[2]), 16'(CLK_HZ / BAUD_RATE[3]),
        16'(CLK_HZ / BAUD_RATE[4]), 16'(CLK_HZ / BAUD_RATE[5]),
        16'(CLK_HZ / BAUD_RATE[6])
    };

    localparam logic [2:0]   BAUD_CODE_FORCED = 3'h4;
    localparam link_cfg_type CFG_FORCED       = '{asciiMode: 1'b1, nodeAddr: 8'h00,
                                                  baudCode: BAUD_CODE_FORCED};
    localparam link_cfg_type CFG_RESET        = CFG_FORCED;

    localparam logic [15:0] IDX_SAVE  = 16'h2066;
    localparam logic [15:0] IDX_GROUP = 16'h2072;
    localparam logic [15:0] IDX_ITEM  = 16'h2073;
    localparam logic [15:0] IDX_VALUE = 16'h207a;
    localparam logic [31:0] SAVE_KEY  = 32'h0000_0004;

    localparam logic [15:0] GROUP_NET  = 16'h0000;
    localparam logic [15:0] ITEM_BAUD  = 16'h0001;
    localparam logic [15:0] ITEM_ADDR  = 16'h0002;
    localparam logic [15:0] ITEM_CHAN  = 16'h0003;
    localparam logic [31:0] CHAN_MODBUS = 32'h0000_0103;
    localparam logic [31:0] CHAN_ASCII  = 32'h0000_0000;
    localparam logic [31:0] ADDR_MIN    = 32'h0000_0001;
    localparam logic [31:0] ADDR_MAX    = 32'h0000_00f7;

    localparam logic [7:0] FC_READ_HOLD  = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [7:0] FC_EXC_FLAG   = 8'h80;
    localparam logic [7:0] EXC_NONE      = 8'h00;
    localparam logic [7:0] EXC_FUNC      = 8'h01;
    localparam logic [7:0] EXC_ADDR      = 8'h02;
    localparam logic [7:0] EXC_VALUE     = 8'h03;

    localparam int         FRAME_MAX = 16;
    localparam logic [4:0] LEN_SHORT = 5'h08;
    localparam logic [4:0] LEN_MANY1 = 5'h0b;
    localparam logic [4:0] LEN_MANY2 = 5'h0d;
    localparam logic [7:0] BC_ONE    = 8'h02;
    localparam logic [7:0] BC_TWO    = 8'h04;
    localparam logic [2:0] LEN_EXC   = 3'h3;
    localparam logic [2:0] LEN_RD1   = 3'h5;
    localparam logic [2:0] LEN_WR    = 3'h6;
    localparam logic [2:0] LEN_RD2   = 3'h7;

    localparam logic [5:0]  GAP_BITS    = 6'h27;
    localparam logic [1:0]  BOOT_CYCLES = 2'h3;
    localparam logic [3:0]  TX_BITS     = 4'hb;
    localparam logic [3:0]  RX_STOP_IDX = 4'ha;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'ha001;

endpackage

// >>> design/serial_byte_rx.sv
`timescale 1ns/10ps
`default_nettype none
module serial_byte_rx
    import modbus_mode_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        rxLevel,
    input  wire logic [15:0] bitCycles,
    output logic             byteValid,
    output logic      [7:0]  byteData,
    output logic             byteBad
);

    logic        busy_q;
    logic        last_q;
    logic [15:0] cnt_q;
    logic [3:0]  idx_q;
    logic [8:0]  shift_q;
    logic        valid_q;
    logic [7:0]  data_q;
    logic        bad_q;
    logic        falling;

    assign falling = last_q && !rxLevel;

    // Samples mid-bit: half a bit after the falling edge, then every bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q  <= 1'b0;
            last_q  <= 1'b1;
            cnt_q   <= 16'h0000;
            idx_q   <= 4'h0;
            shift_q <= 9'h000;
            valid_q <= 1'b0;
            data_q  <= 8'h00;
            bad_q   <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            last_q  <= rxLevel;
            if (!busy_q) begin
                busy_q <= falling;
                cnt_q  <= {1'b0, bitCycles[15:1]};
                idx_q  <= 4'h0;
            end else if (cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end else begin
                cnt_q <= bitCycles - 16'h0001;
                idx_q <= idx_q + 4'h1;
                if (idx_q == 4'h0) begin
                    busy_q <= !rxLevel;
                end else if (idx_q < RX_STOP_IDX) begin
                    shift_q <= {rxLevel, shift_q[8:1]};
                end else begin
                    busy_q  <= 1'b0;
                    valid_q <= 1'b1;
                    data_q  <= shift_q[7:0];
                    // Even parity: data and parity bit together hold an even count
                    bad_q   <= !rxLevel || (^shift_q);
                end
            end
        end
    end

    assign byteValid = valid_q;
    assign byteData  = data_q;
    assign byteBad   = bad_q;

endmodule
`default_nettype wire

// >>> tb/modbus_ascii_mode_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_ascii_mode_control_bench
    import modbus_mode_pkg::*;
;
    localparam link_cfg_type BOOTCFG = '{1'b0, 8'h05, 3'h6};
    localparam link_cfg_type SAVED   = '{1'b1, 8'hf7, 3'h4};
    logic         clk_sys;
    logic         rst_n;
    logic         rxdPin;
    logic         txdPin;
    logic         txdEnable;
    link_cfg_type storedCfg;
    logic         softRestart;
    logic         asciiSave;
    link_cfg_type activeCfg;
    logic         forcedAscii;
    logic         nvmWrite;
    link_cfg_type nvmData;
    logic         saveSeen;
    int           errors;
    int           samples_checked;
    modbus_ascii_mode_control uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .rxdPin(rxdPin), .txdPin(txdPin),
        .txdEnable(txdEnable), .storedCfg(storedCfg), .softRestart(softRestart),
        .asciiSave(asciiSave), .activeCfg(activeCfg), .forcedAscii(forcedAscii),
        .nvmWrite(nvmWrite), .nvmData(nvmData));
    modbus_master_model master (.clk_sys(clk_sys), .txdPin(txdPin), .rxdLine(rxdPin));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (nvmWrite === 1'b1) saveSeen <= 1'b1;
    task automatic conclude;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic boot(input logic rxd);
        rst_n = 1'b0;
        master.rxdLine = rxd;
        tick(6);
        check({txdPin, txdEnable, nvmWrite}, 16'h4);
        rst_n = 1'b1;
        tick(8);
        master.rxdLine = 1'b1;
        tick(2);
    endtask
    task automatic xact(input logic [103:0] req, input int len, input logic bad,
                        input logic [63:0] want, input int n);
        logic [15:0] c;
        int          k;
        master.rxq.delete();
        master.sendFrame(req, len, bad);
        for (k = 0; k < 1500 && txdEnable !== 1'b1; k++) tick(1);
        for (k = 0; k < 3000 && txdEnable === 1'b1; k++) tick(1);
        if (k == 3000) begin
            errors++;
            conclude();
        end
        tick(30);
        c = master.crc16(104'(want), n);
        check(16'(master.rxq.size()), 16'(n > 0 ? n + 2 : 0));
        if (n > 0 && master.rxq.size() == n + 2) begin
            for (int i = 0; i < n; i++)
                check(16'(master.rxq[i]), 16'(want[8*(n-1-i)+:8]));
            check({master.rxq[n+1], master.rxq[n]}, c);
        end
    endtask
    task automatic wr(input logic [31:0] iv);
        xact({16'h0506, iv}, 6, 1'b0, 64'({16'h0506, iv}), 6);
    endtask
    task automatic sc_settings;
        wr(32'h2072_0000);
        wr(32'h2073_0003);
        for (logic [7:0] f = 8'h03; f <= 8'h04; f++)
            xact({8'h05, f, 32'h2073_0001}, 6, 1'b0, {8'h05, f, 24'h02_0003}, 5);
        xact(48'h05_03_2073_0002, 6, 1'b0, 56'h05_03_04_0000_0003, 7);
        wr(32'h207a_0103);
        wr(32'h207a_0000);
        xact(48'h06_06_2072_0000, 6, 1'b0, 64'h0, 0);
        xact(48'h05_06_2072_0000, 6, 1'b1, 64'h0, 0);
        xact(48'h05_05_2072_0000, 6, 1'b0, 64'h05_85_01, 3);
        xact(48'h05_03_2066_0001, 6, 1'b0, 64'h05_83_02, 3);
        wr(32'h2073_0002);
        xact(48'h05_06_207a_00f8, 6, 1'b0, 64'h05_86_03, 3);
        wr(32'h207a_00f7);
        wr(32'h2073_0001);
        xact(48'h05_06_207a_2581, 6, 1'b0, 64'h05_86_03, 3);
        xact(88'h05_10_207a_0002_04_0001_c200, 11, 1'b0, 48'h05_10_207a_0002, 6);
    endtask
    task automatic sc_save_restart;
        saveSeen = 1'b0;
        wr(32'h2066_0004);
        check(16'(saveSeen), 16'h1);
        check(16'(nvmData), 16'(SAVED));
        check(16'(activeCfg), 16'(BOOTCFG));
        storedCfg = SAVED;
        softRestart = 1'b1;
        tick(1);
        softRestart = 1'b0;
        tick(10);
        check(16'(activeCfg), 16'(SAVED));
        xact(48'hf7_06_2072_0000, 6, 1'b0, 64'h0, 0);
    endtask
    task automatic sc_forced;
        boot(1'b0);
        check(16'(forcedAscii), 16'h1);
        check(16'(activeCfg), 16'(CFG_FORCED));
        saveSeen = 1'b0;
        asciiSave = 1'b1;
        tick(1);
        asciiSave = 1'b0;
        tick(3);
        check(16'(saveSeen), 16'h1);
        check(16'(nvmData), 16'(CFG_FORCED));
        boot(1'b1);
        check(16'(activeCfg), 16'(SAVED));
        check(16'(forcedAscii), 16'h0);
    endtask
    initial begin
        errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        storedCfg = BOOTCFG;
        softRestart = 1'b0;
        asciiSave = 1'b0;
        saveSeen = 1'b0;
        boot(1'b1);
        check(16'(activeCfg), 16'(BOOTCFG));
        sc_settings();
        sc_save_restart();
        sc_forced();
        conclude();
    end
endmodule
`default_nettype wire

// >>> tb/modbus_ascii_mode_control_props.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_ascii_mode_control_props
    import modbus_mode_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire logic         txdPin,
    input wire logic         txdEnable,
    input wire link_cfg_type activeCfg,
    input wire logic         forcedAscii,
    input wire logic         nvmWrite,
    input wire link_cfg_type nvmData
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [10:0] startWait_q;
    // Slowest rate needs more than a delay range allows
    always_ff @(posedge clk_sys) begin
        startWait_q <= !txdEnable ? 11'h001
                     : (txdPin && startWait_q != 11'h000) ? startWait_q + 11'h001 : 11'h000;
    end
    a_txd_idle: assert property (!txdEnable |-> txdPin)
        else $error("txd low outside an answer");
    a_save_pulse: assert property (nvmWrite |=> !nvmWrite)
        else $error("save strobe longer than one cycle");
    a_forced_cfg: assert property (forcedAscii |-> activeCfg == CFG_FORCED)
        else $error("forced start with wrong setup");
    a_save_addr: assert property (nvmWrite |-> nvmData.nodeAddr <= 8'hf7)
        else $error("saved address out of range");
    a_save_baud: assert property (nvmWrite |-> nvmData.baudCode < 3'h7)
        else $error("saved rate code out of range");
    a_answer_modbus: assert property ($rose(txdEnable) |-> !activeCfg.asciiMode)
        else $error("answer sent in ascii mode");
    a_cfg_frozen: assert property (txdEnable |=> $stable(activeCfg))
        else $error("setup changed while answering");
    a_start_bit: assert property (startWait_q <= 11'h420)
        else $error("no start bit after enable");
endmodule
bind modbus_ascii_mode_control modbus_ascii_mode_control_props chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .txdPin(txdPin), .txdEnable(txdEnable),
    .activeCfg(activeCfg), .forcedAscii(forcedAscii), .nvmWrite(nvmWrite),
    .nvmData(nvmData));
`default_nettype wire

// >>> tb/modbus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model #(
    parameter int BIT = 21
) (
    input  wire logic clk_sys,
    input  wire logic txdPin,
    output var logic  rxdLine
);
    logic [7:0] rxq [$];
    initial rxdLine = 1'b1;
    function automatic logic [15:0] crc16(input logic [103:0] d, input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = n - 1; i >= 0; i--) begin
            c = c ^ 16'(d[8*i+:8]);
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic sendByte(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_sys);
            #1 rxdLine = f[i];
            repeat (BIT - 1) @(posedge clk_sys);
        end
    endtask
    task automatic sendFrame(input logic [103:0] r, input int n, input logic bad);
        logic [15:0] c;
        c = crc16(r, n) ^ 16'(bad);
        for (int i = n - 1; i >= 0; i--)
            sendByte(r[8*i+:8]);
        sendByte(c[7:0]);
        sendByte(c[15:8]);
    endtask
    // Mid-bit sampling tolerates the truncated bit period
    always begin
        logic [8:0] s;
        @(negedge txdPin);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk_sys);
            s[i] = txdPin;
        end
        if (^s == 1'b0)
            rxq.push_back(s[7:0]);
        repeat (BIT) @(posedge clk_sys);
    end
endmodule
`default_nettype wire
